// >>> adcs_consts.svh
// Constant definitions for the conversion sequencer.
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

`define ADCS_CH_W        5
`define ADCS_CH_DISABLED 5'h1F
`define ADCS_CLK_BUS     2'h0
`define ADCS_CLK_HALF    2'h1
`define ADCS_CLK_ALT     2'h2
`define ADCS_CLK_ASYNC   2'h3
`define ADCS_DIV_1       2'h0
`define ADCS_DIV_2       2'h1
`define ADCS_DIV_4       2'h2
`define ADCS_DIV_8       2'h3
`define ADCS_MODE_8BIT   2'h0
`define ADCS_MODE_10BIT  2'h2
`define ADCS_RES_HI_RST  2'h0
`define ADCS_RES_LO_RST  8'h00
`define ADCS_MAX10       10'h3FF
`define ADCS_MAX8        8'hFF
`define ADCS_ASYNC_HALF  4

`endif

// >>> adcs_pkg.sv
// Types shared by the conversion sequencer.
`include "adcs_consts.svh"
package adcs_pkg;

    typedef enum logic [0:0] {
        ADCS_IDLE = 1'b0,
        ADCS_CONV = 1'b1
    } adcs_state_t;

    typedef struct packed {
        logic [1:0] width_mode;
        logic       trigger_select;
        logic       continuous_enable;
        logic       compare_function_enable;
        logic       compare_greater;
        logic       complete_interrupt_enable;
        logic [1:0] input_clock_select;
        logic [1:0] clock_divide_select;
        logic       low_power_config;
    } adcs_cfg_t;

    typedef struct packed {
        logic       stc1;
        logic       stc2;
        logic       cfg;
        logic       cvh;
        logic       cvl;
    } adcs_wr_t;

endpackage : adcs_pkg

// >>> adcs_sequencer.sv
// Conversion sequencer: start, abort, clocking, rounding and result transfer.
`include "adcs_consts.svh"
module adcs_sequencer #(
    parameter int PINS = 8
) (
    input  wire logic                      ref_clk,
    input  wire logic                      sys_rst,
    input  wire adcs_pkg::adcs_cfg_t       cfg,
    input  wire adcs_pkg::adcs_wr_t        wr,
    input  wire logic [`ADCS_CH_W-1:0]     channel_select,
    input  wire logic [9:0]                compare_value,
    input  wire logic                      rd_result_high,
    input  wire logic                      rd_result_low,
    input  wire logic                      stop_mode_entry,
    input  wire logic                      hardware_trigger_input,
    input  wire logic                      alternate_clock,
    input  wire logic                      sar_done,
    input  wire logic [10:0]               sar_value,
    input  wire logic [PINS-1:0]           pin_control_bits,
    input  wire logic [PINS-1:0]           port_oe_req,
    input  wire logic [PINS-1:0]           port_pullup_req,
    input  wire logic [PINS-1:0]           pin_in,
    output logic                           sar_start,
    output logic                           sar_abort,
    output logic                           converter_clock,
    output logic                           async_gen_enable,
    output logic                           low_power_request,
    output logic                           busy,
    output logic [1:0]                     result_high,
    output logic [7:0]                     result_low,
    output logic                           conversion_complete_flag,
    output logic                           conv_irq,
    output logic [PINS-1:0]                pin_oe,
    output logic [PINS-1:0]                pin_pullup,
    output logic [PINS-1:0]                port_read
);
    import adcs_pkg::*;
    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic trig_s1, trig_s2, trig_d;
    logic alt_s1, alt_s2, alt_d;
    logic hw_rise, alt_rise;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_d  <= 1'b0;
            alt_s1  <= 1'b0;
            alt_s2  <= 1'b0;
            alt_d   <= 1'b0;
        end else begin
            trig_s1 <= hardware_trigger_input;
            trig_s2 <= trig_s1;
            trig_d  <= trig_s2;
            alt_s1  <= alternate_clock;
            alt_s2  <= alt_s1;
            alt_d   <= alt_s2;
        end
    end

    assign hw_rise  = trig_s2 & ~trig_d;
    assign alt_rise = alt_s2 & ~alt_d;

    // ------------------------------------------------------------
    // Start and abort decisions
    // ------------------------------------------------------------
    adcs_state_t state;
    logic        chan_off, cfg_write, stop_abort, abort_now;
    logic        sw_start, hw_start, cmp_true, blocked, xfer, relaunch;
    logic        next_start, high_read_pending;
    logic [9:0]  raw_round, cmp_diff, xfer_val;
    logic [10:0] round_sum;

    assign chan_off   = channel_select == `ADCS_CH_DISABLED;
    assign cfg_write  = wr.stc2 | wr.cfg | wr.cvh | wr.cvl;
    assign stop_abort = stop_mode_entry &&
        cfg.input_clock_select != `ADCS_CLK_ASYNC;
    assign abort_now  = wr.stc1 | cfg_write | stop_abort | chan_off;
    assign sw_start   = wr.stc1 && !chan_off &&
        !cfg.trigger_select;
    // Trigger edges only act while idle, so a running continuous
    // sequence never sees a later edge.
    assign hw_start   = cfg.trigger_select && hw_rise && !chan_off &&
        state == ADCS_IDLE && !abort_now;

    // Rounding to the output width, saturating at full scale.
    always_comb begin
        round_sum = 11'h000;
        raw_round = 10'h000;
        if (cfg.width_mode == `ADCS_MODE_10BIT) begin
            round_sum = {1'b0, sar_value[10:1]} + {10'h000, sar_value[0]};
            raw_round = round_sum[10] ? `ADCS_MAX10 : round_sum[9:0];
        end else begin
            round_sum = {3'h0, sar_value[8:1]} + {10'h000, sar_value[0]};
            raw_round = round_sum[8] ? {2'h0, `ADCS_MAX8}
                                     : {2'h0, round_sum[7:0]};
        end
    end

    assign cmp_diff = raw_round - compare_value;
    assign cmp_true = !cfg.compare_function_enable ||
        (cfg.compare_greater ? raw_round >= compare_value
                             : raw_round <  compare_value);
    assign xfer_val = cfg.compare_function_enable ? cmp_diff : raw_round;
    assign blocked  = high_read_pending &&
        cfg.width_mode == `ADCS_MODE_10BIT;
    assign xfer     = state == ADCS_CONV && sar_done && !abort_now &&
        cmp_true && !blocked;

    // A finished conversion relaunches in continuous mode, and also when
    // its transfer was blocked, unless it was a single compare-false one.
    always_comb begin
        relaunch = 1'b0;
        if (state == ADCS_CONV && sar_done && !abort_now) begin
            if (!cmp_true)
                relaunch = cfg.continuous_enable;
            else if (blocked)
                relaunch = 1'b1;
            else
                relaunch = cfg.continuous_enable;
        end
    end

    assign next_start = sw_start | hw_start | relaunch;

    // ------------------------------------------------------------
    // Sequencing state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= ADCS_IDLE;
        end else if (next_start) begin
            state <= ADCS_CONV;
        end else if (abort_now || (state == ADCS_CONV && sar_done)) begin
            state <= ADCS_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sar_start <= 1'b0;
            sar_abort <= 1'b0;
            busy      <= 1'b0;
        end else begin
            sar_start <= next_start;
            sar_abort <= abort_now && state == ADCS_CONV;
            busy      <= next_start ||
                (state == ADCS_CONV && !abort_now && !sar_done);
        end
    end

    // ------------------------------------------------------------
    // Clock select and divide
    // ------------------------------------------------------------
    logic       half_ph, src_tick, async_tick;
    logic [2:0] div_cnt, div_mask;
    logic [$clog2(`ADCS_ASYNC_HALF)-1:0] async_cnt;

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !async_gen_enable) begin
            async_cnt <= '0;
        end else begin
            async_cnt <= async_cnt + 1'b1;
        end
    end
    assign async_tick = async_gen_enable && (&async_cnt);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            half_ph <= 1'b0;
        end else begin
            half_ph <= ~half_ph;
        end
    end

    always_comb begin
        case (cfg.input_clock_select)
            `ADCS_CLK_BUS:  src_tick = 1'b1;
            `ADCS_CLK_HALF: src_tick = half_ph;
            `ADCS_CLK_ALT:  src_tick = alt_rise;
            default:        src_tick = async_tick;
        endcase
        case (cfg.clock_divide_select)
            `ADCS_DIV_1: div_mask = 3'h0;
            `ADCS_DIV_2: div_mask = 3'h1;
            `ADCS_DIV_4: div_mask = 3'h3;
            default:     div_mask = 3'h7;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || state != ADCS_CONV) begin
            div_cnt         <= 3'h0;
            converter_clock <= 1'b0;
        end else begin
            converter_clock <= src_tick && div_cnt == div_mask;
            if (src_tick) begin
                div_cnt <= (div_cnt == div_mask) ? 3'h0 : div_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            async_gen_enable  <= 1'b0;
            low_power_request <= 1'b0;
        end else begin
            if (next_start && cfg.input_clock_select == `ADCS_CLK_ASYNC)
                async_gen_enable <= 1'b1;
            else if (!next_start && state != ADCS_CONV)
                async_gen_enable <= 1'b0;
            low_power_request <= cfg.low_power_config;
        end
    end

    // ------------------------------------------------------------
    // Result transfer, flag and read blocking
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            result_high <= `ADCS_RES_HI_RST;
            result_low  <= `ADCS_RES_LO_RST;
        end else if (xfer) begin
            result_low <= xfer_val[7:0];
            if (cfg.width_mode == `ADCS_MODE_10BIT)
                result_high <= xfer_val[9:8];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            conversion_complete_flag <= 1'b0;
            conv_irq                 <= 1'b0;
            high_read_pending        <= 1'b0;
        end else begin
            // A transfer in the same cycle as a clear keeps the flag set.
            if (xfer)
                conversion_complete_flag <= 1'b1;
            else if (wr.stc1 || rd_result_low)
                conversion_complete_flag <= 1'b0;
            conv_irq <= cfg.complete_interrupt_enable &&
                (xfer || (conversion_complete_flag &&
                 !(wr.stc1 || rd_result_low)));
            if (rd_result_low)
                high_read_pending <= 1'b0;
            else if (rd_result_high)
                high_read_pending <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pin digital interface control
    // ------------------------------------------------------------
    logic [PINS-1:0] pin_s1, pin_s2;

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                pin_s1[i]     <= 1'b0;
                pin_s2[i]     <= 1'b0;
                pin_oe[i]     <= 1'b0;
                pin_pullup[i] <= 1'b0;
                port_read[i]  <= 1'b0;
            end else begin
                pin_s1[i]     <= pin_in[i];
                pin_s2[i]     <= pin_s1[i];
                pin_oe[i]     <= port_oe_req[i] & ~pin_control_bits[i];
                pin_pullup[i] <= port_pullup_req[i] & ~pin_control_bits[i];
                port_read[i]  <= pin_s2[i] & ~pin_control_bits[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_pin_off;
        pin_control_bits[0] ##1 pin_control_bits[0];
    endsequence
    sequence s_blocked_done;
        state == ADCS_CONV && sar_done && !abort_now && blocked && cmp_true;
    endsequence

    a_pin_forced_off: assert property (
        s_pin_off |-> !pin_oe[0] && !pin_pullup[0] && !port_read[0])
        else $error("Pin not forced digital off.");
    a_trig_ignored_busy: assert property (
        hw_rise && state == ADCS_CONV && !abort_now && !sar_done |=>
        !sar_start)
        else $error("Trigger edge started a running conversion.");
    a_chan_off_idle: assert property (chan_off |=> !busy && !sar_start)
        else $error("Converter busy with channel disabled.");
    a_xfer_sets_flag: assert property (xfer |=>
        conversion_complete_flag && (conv_irq == cfg.complete_interrupt_enable))
        else $error("Transfer did not set flag or interrupt.");
    a_block_discard: assert property (s_blocked_done |=>
        $stable(result_low) && $stable(result_high) && sar_start)
        else $error("Blocked result was transferred.");
    a_cont_relaunch: assert property (
        xfer && cfg.continuous_enable |=> sar_start ##1 busy)
        else $error("Continuous mode did not relaunch.");
    a_abort_keeps: assert property (cfg_write && !xfer |=>
        $stable(result_low) && $stable(result_high) && !busy)
        else $error("Abort altered results or left converter busy.");
    a_narrow_high: assert property (
        xfer && cfg.width_mode == `ADCS_MODE_8BIT |=> $stable(result_high))
        else $error("8-bit transfer touched the high result.");
    a_bus_clk_tick: assert property (
        (state == ADCS_CONV && cfg.input_clock_select == `ADCS_CLK_BUS &&
         cfg.clock_divide_select == `ADCS_DIV_1)[*2] |-> converter_clock)
        else $error("Undivided bus clock gave no converter tick.");

endmodule : adcs_sequencer

// >>> adcs_sar_model.sv
// Behavioural converter model that answers start requests after a delay.
module adcs_sar_model (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        sar_start,
    input  wire logic        sar_abort,
    input  wire logic [10:0] raw,
    input  wire logic [7:0]  lat,
    output logic             sar_done,
    output logic [10:0]      sar_value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       run;
    logic [7:0] cnt;
    // The value lines toggle outside the done cycle, so stale data shows.
    always_ff @(posedge ref_clk) begin
        sar_done <= 1'b0;
        sar_value <= ~sar_value;
        if (sys_rst) begin
            run <= 1'b0;
            cnt <= 8'h00;
            sar_value <= 11'h000;
        // A restart that comes with an abort, as after a control-one
        // write during a conversion, launches the new conversion.
        end else if (sar_start) begin
            run <= 1'b1;
            cnt <= lat;
        end else if (sar_abort) begin
            run <= 1'b0;
        end else if (run && cnt == 8'h00) begin
            run <= 1'b0;
            sar_done <= 1'b1;
            sar_value <= raw;
        end else if (run) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : adcs_sar_model

// >>> adcs_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer.
`include "adcs_consts.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module adcs_sequencer_tb_top;
    import adcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    adcs_cfg_t cfg;
    adcs_wr_t wr = '0;
    logic [4:0] ch = 5'h03;
    logic [9:0] cv = 10'h000;
    logic rd_hi = 1'b0, rd_lo = 1'b0, stop = 1'b0, hwt = 1'b0;
    logic [7:0] pcb = 8'h00, oe_req = 8'hFF, pu_req = 8'hFF, pin = 8'hFF;
    logic [10:0] raw = 11'h000;
    logic [7:0] lat = 8'h06;
    logic sar_done, sar_start, sar_abort, cclk, agen, lpr, busy, flag, irq;
    logic [10:0] sar_value;
    logic [1:0] rh;
    logic [7:0] rl, p_oe, p_pu, p_rd;
    int err_total = 0, compares = 0, starts = 0, aborts = 0, cyc = 0;
    int ticks = 0, bcyc = 0;
    logic alt = 1'b0;
    always #2.5 ref_clk = ~ref_clk;
    adcs_sequencer i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg(cfg),
        .wr(wr), .channel_select(ch), .compare_value(cv),
        .rd_result_high(rd_hi), .rd_result_low(rd_lo),
        .stop_mode_entry(stop), .hardware_trigger_input(hwt),
        .alternate_clock(alt), .sar_done(sar_done), .sar_value(sar_value),
        .pin_control_bits(pcb), .port_oe_req(oe_req),
        .port_pullup_req(pu_req), .pin_in(pin), .sar_start(sar_start),
        .sar_abort(sar_abort), .converter_clock(cclk),
        .async_gen_enable(agen), .low_power_request(lpr), .busy(busy),
        .result_high(rh), .result_low(rl), .conversion_complete_flag(flag),
        .conv_irq(irq), .pin_oe(p_oe), .pin_pullup(p_pu), .port_read(p_rd));
    adcs_sar_model i_sar (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sar_start(sar_start), .sar_abort(sar_abort), .raw(raw), .lat(lat),
        .sar_done(sar_done), .sar_value(sar_value));
    always @(posedge ref_clk) begin
        starts += (sar_start === 1'b1);
        aborts += (sar_abort === 1'b1);
        ticks += (cclk === 1'b1);
        bcyc += (busy === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tick(int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    task automatic wr_pulse(adcs_wr_t w);
        @(negedge ref_clk) wr = w;
        @(negedge ref_clk) wr = '0;
    endtask : wr_pulse
    task automatic go(logic [10:0] v);
        raw = v;
        wr_pulse(adcs_wr_t'(5'h10));
    endtask : go
    task automatic wait_sar();
        int n;
        n = 0;
        while (sar_done !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        tick(1);
    endtask : wait_sar
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_ten();
        logic [10:0] vin [2] = '{11'h2FF, 11'h7FF};
        logic [9:0] vexp [2] = '{10'h180, 10'h3FF};
        for (int i = 0; i < 2; i++) begin
            go(vin[i]);
            `CHK("start", 1'b1, sar_start)
            wait_sar();
            `CHK("res10", vexp[i], {rh, rl})
            `CHK("flag", 1'b1, flag)
            `CHK("irq", 1'b1, irq)
            `CHK("idle", 1'b0, busy)
        end
    endtask : t_ten
    task automatic t_eight();
        cfg.width_mode = `ADCS_MODE_8BIT;
        go(11'h6FE);
        wait_sar();
        `CHK("res8", 8'h7F, rl)
        `CHK("hi8", 2'h3, rh)
        cfg.width_mode = `ADCS_MODE_10BIT;
    endtask : t_eight
    task automatic t_off();
        int s0;
        s0 = starts;
        ch = `ADCS_CH_DISABLED;
        go(11'h001);
        tick(3);
        `CHK("off", 0, starts - s0)
        `CHK("offbusy", 1'b0, busy)
        ch = 5'h03;
    endtask : t_off
    task automatic t_abort();
        int a0;
        lat = 8'h28;
        for (int i = 0; i < 5; i++) begin
            a0 = aborts;
            go(11'h001);
            tick(3);
            if (i < 4) wr_pulse(adcs_wr_t'(5'h08 >> i));
            else begin
                stop = 1'b1;
                tick(1);
                stop = 1'b0;
            end
            tick(1);
            `CHK("abusy", 1'b0, busy)
            `CHK("apulse", 1, aborts - a0)
            `CHK("akeep", 10'h37F, {rh, rl})
        end
        lat = 8'h06;
    endtask : t_abort
    task automatic t_hwt();
        int s0;
        s0 = starts;
        cfg.trigger_select = 1'b1;
        lat = 8'h1E;
        hwt = 1'b1;
        tick(6);
        `CHK("hwbusy", 1'b1, busy)
        hwt = 1'b0;
        tick(3);
        hwt = 1'b1;
        wait_sar();
        tick(10);
        `CHK("hwone", 1, starts - s0)
        s0 = starts;
        cfg.continuous_enable = 1'b1;
        hwt = 1'b0;
        tick(3);
        hwt = 1'b1;
        tick(8);
        hwt = 1'b0;
        tick(3);
        hwt = 1'b1;
        wait_sar();
        tick(1);
        `CHK("hwcont", 2, starts - s0)
        cfg.continuous_enable = 1'b0;
        wr_pulse(adcs_wr_t'(5'h08));
        hwt = 1'b0;
        cfg.trigger_select = 1'b0;
        lat = 8'h06;
    endtask : t_hwt
    task automatic t_cont();
        int s0;
        s0 = starts;
        cfg.continuous_enable = 1'b1;
        go(11'h2FF);
        wait_sar();
        wait_sar();
        tick(1);
        `CHK("cont", 3, starts - s0)
        cfg.continuous_enable = 1'b0;
        ch = `ADCS_CH_DISABLED;
        go(11'h2FF);
        ch = 5'h03;
    endtask : t_cont
    task automatic t_block();
        int s0;
        go(11'h2FF);
        wait_sar();
        wr_pulse(adcs_wr_t'(5'h00));
        rd_hi = 1'b1;
        tick(1);
        rd_hi = 1'b0;
        s0 = starts;
        go(11'h101);
        wait_sar();
        tick(1);
        `CHK("blkres", 10'h180, {rh, rl})
        `CHK("blkflag", 1'b0, flag)
        `CHK("blkrun", 2, starts - s0)
        rd_lo = 1'b1;
        tick(1);
        rd_lo = 1'b0;
        wait_sar();
        `CHK("blknew", 10'h081, {rh, rl})
    endtask : t_block
    task automatic t_cmp();
        cfg.compare_function_enable = 1'b1;
        cfg.compare_greater = 1'b1;
        cv = 10'h100;
        go(11'h2FF);
        wait_sar();
        `CHK("cmpres", 10'h080, {rh, rl})
        cv = 10'h200;
        go(11'h2FF);
        wait_sar();
        tick(3);
        `CHK("cmpflag", 1'b0, flag)
        `CHK("cmpstop", 1'b0, busy)
        `CHK("cmpkeep", 10'h080, {rh, rl})
        cfg.compare_function_enable = 1'b0;
    endtask : t_cmp
    task automatic t_div();
        int t0, b0, exp_t;
        for (int i = 0; i < 3; i++) begin
            cfg.input_clock_select = (i == 2) ? `ADCS_CLK_ALT : `ADCS_CLK_BUS;
            cfg.clock_divide_select = (i == 1) ? `ADCS_DIV_4 : `ADCS_DIV_1;
            t0 = ticks;
            b0 = bcyc;
            go(11'h2FF);
            alt = (i == 2);
            wait_sar();
            alt = 1'b0;
            tick(2);
            exp_t = (i == 2) ? 1 : (bcyc - b0) >> (2 * i);
            `CHK("cclk", exp_t, ticks - t0)
        end
        cfg.input_clock_select = `ADCS_CLK_BUS;
        cfg.clock_divide_select = `ADCS_DIV_1;
    endtask : t_div
    task automatic t_async();
        cfg.input_clock_select = `ADCS_CLK_ASYNC;
        lat = 8'h1E;
        go(11'h2FF);
        stop = 1'b1;
        tick(4);
        stop = 1'b0;
        `CHK("agen", 1'b1, agen)
        `CHK("astop", 1'b1, busy)
        wait_sar();
        tick(2);
        `CHK("agenoff", 1'b0, agen)
        cfg.input_clock_select = `ADCS_CLK_BUS;
        lat = 8'h06;
    endtask : t_async
    task automatic t_pins();
        pcb = 8'h0F;
        cfg.low_power_config = 1'b1;
        tick(4);
        `CHK("oe", 8'hF0, p_oe)
        `CHK("pu", 8'hF0, p_pu)
        `CHK("rd", 8'hF0, p_rd)
        `CHK("lp", 1'b1, lpr)
    endtask : t_pins
    task automatic complete_run();
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        cfg = '0;
        cfg.width_mode = `ADCS_MODE_10BIT;
        cfg.complete_interrupt_enable = 1'b1;
        tick(16);
        sys_rst = 1'b0;
        `CHK("rstres", 10'h000, {rh, rl})
        `CHK("rstflag", 1'b0, flag)
        t_ten();
        t_eight();
        t_off();
        t_abort();
        t_hwt();
        t_cont();
        t_block();
        t_cmp();
        t_div();
        t_async();
        t_pins();
        complete_run();
    end
endmodule : adcs_sequencer_tb_top
